// ---- common/scpm_pkg.sv ----
// Operation
// R01: Two internal RC sources are provided, a fast one at 8MHz and a slow one at 32kHz, needing no external parts.
// R02: The oscillators also feed the watchdog clock and the time-base clock; here only the slow oscillator drives both.
// R03: The system clock is the fast clock, a divided fast clock or the sub clock, per fast_clock_select and slow_clock_divider_select.
// R04: In NORMAL the CPU runs from the fast oscillator divided by 1 to 64 as the select bits say.
// R05: NORMAL takes its clock from the fast oscillator with the CPU running and the sub clock on.
// R06: In SLOW the CPU runs from the slow oscillator and the fast clock is off.
// R07: Moving the system clock from fast to sub stops the fast oscillator, so no fast clocks remain.
// R08: SLEEP0, SLEEP1, IDLE0 and IDLE1 stop the CPU, giving six modes in all.
// R09: Power-down with halt_idle_select low and watchdog off enters SLEEP0 with CPU, system and sub clocks stopped.
// R10: Power-down with halt_idle_select low and watchdog on enters SLEEP1, where only the sub clock keeps running.
// R11: In either SLEEP mode the low-voltage detector is forced off whatever voltage_detect_enable says.
// R12: Power-down with halt_idle_select high and idle_sysclk_keep low enters IDLE0: system clock stopped, sub clock on.
// R13: Power-down with halt_idle_select high and idle_sysclk_keep high enters IDLE1: CPU gated, system and sub clocks on.
// R14: With fast_clock_select low, divider codes 000 and 001 pick the sub clock and 010 to 111 pick fast/64 down to fast/2.
// R15: fast_clock_select high picks the undivided fast clock; low defers to the divider field.
// R16: A clock change takes effect only once the new oscillator is ready and at a boundary of the old clock.
package scpm_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint FAST_HZ = 8_000_000;
  localparam longint SLOW_HZ = 32_000;
  localparam int ACC_W = 16;
  localparam logic [ACC_W-1:0] FAST_INC =
    ACC_W'((FAST_HZ << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] SLOW_INC =
    ACC_W'((SLOW_HZ << ACC_W) / CLK_HZ);

  // Oscillator start-up counts in clk cycles
  localparam int FAST_START_CYC = 64;
  localparam int SLOW_START_CYC = 256;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_LVD = 2'h2;

  localparam int MODE_CKS_LSB = 5;
  localparam int MODE_SLOW_RDY_BIT = 3;
  localparam int MODE_FAST_RDY_BIT = 2;
  localparam int MODE_IDLE_BIT = 1;
  localparam int MODE_HL_BIT = 0;
  localparam int CTRL_KEEP_BIT = 7;
  localparam int LVD_EN_BIT = 0;

  localparam logic [2:0] CKS_RST = 3'h7;
  localparam logic IDLE_RST = 1'h1;
  localparam logic HL_RST = 1'h0;
  localparam logic KEEP_RST = 1'h0;
  localparam logic LVD_RST = 1'h0;

  // Divider codes: up to CKS_SUB_MAX is the sub clock, CKS_DIV64 is /64
  localparam logic [2:0] CKS_SUB_MAX = 3'h1;
  localparam logic [2:0] CKS_DIV64 = 3'h2;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_NORMAL = 6'h01,
    MODE_SLOW = 6'h02,
    MODE_IDLE0 = 6'h04,
    MODE_IDLE1 = 6'h08,
    MODE_SLEEP0 = 6'h10,
    MODE_SLEEP1 = 6'h20
  } scpm_mode_t;

endpackage

// ---- rtl/scpm_clock_power_ctrl.sv ----
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module scpm_clock_power_ctrl #(
  parameter int FAST_START_CYC = scpm_pkg::FAST_START_CYC,
  parameter int SLOW_START_CYC = scpm_pkg::SLOW_START_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [scpm_pkg::ADDR_W-1:0] addr,
  input wire logic [scpm_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [scpm_pkg::DATA_W-1:0] rdata,
  // Core requests
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enable,
  // Clock enables to consumers
  output logic core_clock_en,
  output logic cpu_clock_en,
  output logic fast_clock_en,
  output logic sub_clock_en,
  output logic wdt_clock_en,
  output logic timebase_clock_en,
  // Status
  output logic fast_osc_on,
  output logic slow_osc_on,
  output logic lvd_active,
  output scpm_pkg::scpm_mode_t mode_state
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (FAST_START_CYC < 1 || FAST_START_CYC > 65535) begin
      $error("FAST_START_CYC out of range");
    end
    if (SLOW_START_CYC < 1 || SLOW_START_CYC > 65535) begin
      $error("SLOW_START_CYC out of range");
    end
  end

  localparam logic [15:0] FAST_START = 16'(FAST_START_CYC);
  localparam logic [15:0] SLOW_START = 16'(SLOW_START_CYC);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] slow_clock_divider_select;
  logic halt_idle_select;
  logic fast_clock_select;
  logic idle_sysclk_keep;
  logic voltage_detect_enable;
  logic [2:0] active_cks;
  logic active_hl;
  logic [15:0] fast_cnt;
  logic [15:0] slow_cnt;
  logic [scpm_pkg::ACC_W-1:0] fast_acc;
  logic [scpm_pkg::ACC_W-1:0] slow_acc;
  logic fast_tick;
  logic slow_tick;
  logic [5:0] div_cnt;
  logic fast_ready;
  logic slow_ready;
  logic target_fast;
  logic active_fast;
  logic src_tick;
  logic switch_ok;
  logic run_mode;
  logic sys_on;
  logic sleep_mode;
  logic next_fast_on;
  logic next_slow_on;
  scpm_pkg::scpm_mode_t next_mode;

  // Divided fast tick: high when the low bits of the count wrap
  function automatic logic div_hit(input logic [5:0] cnt,
                                   input logic [2:0] code);
    logic [5:0] mask;
    mask = 6'h3F >> (code - scpm_pkg::CKS_DIV64);
    return (cnt & mask) == mask;
  endfunction

  function automatic logic is_fast(input logic hl, input logic [2:0] cks);
    return hl || (cks > scpm_pkg::CKS_SUB_MAX);
  endfunction

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slow_clock_divider_select <= scpm_pkg::CKS_RST;
      halt_idle_select <= scpm_pkg::IDLE_RST;
      fast_clock_select <= scpm_pkg::HL_RST;
      idle_sysclk_keep <= scpm_pkg::KEEP_RST;
      voltage_detect_enable <= scpm_pkg::LVD_RST;
    end else if (wr_en) begin
      unique case (addr)
        scpm_pkg::ADDR_MODE: begin
          slow_clock_divider_select <=
            wdata[scpm_pkg::MODE_CKS_LSB +: 3];
          halt_idle_select <= wdata[scpm_pkg::MODE_IDLE_BIT];
          fast_clock_select <= wdata[scpm_pkg::MODE_HL_BIT];
        end
        scpm_pkg::ADDR_CTRL: begin
          idle_sysclk_keep <= wdata[scpm_pkg::CTRL_KEEP_BIT];
        end
        scpm_pkg::ADDR_LVD: begin
          voltage_detect_enable <= wdata[scpm_pkg::LVD_EN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= '0;
      unique case (addr)
        scpm_pkg::ADDR_MODE: begin
          rdata[scpm_pkg::MODE_CKS_LSB +: 3] <= slow_clock_divider_select;
          rdata[scpm_pkg::MODE_SLOW_RDY_BIT] <= slow_ready;
          rdata[scpm_pkg::MODE_FAST_RDY_BIT] <= fast_ready;
          rdata[scpm_pkg::MODE_IDLE_BIT] <= halt_idle_select;
          rdata[scpm_pkg::MODE_HL_BIT] <= fast_clock_select;
        end
        scpm_pkg::ADDR_CTRL: begin
          rdata[scpm_pkg::CTRL_KEEP_BIT] <= idle_sysclk_keep;
        end
        scpm_pkg::ADDR_LVD: begin
          rdata[scpm_pkg::LVD_EN_BIT] <= voltage_detect_enable;
        end
        default: begin
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator models
  // ----------------------------------------------------------------
  // Each source is a phase accumulator ticking at its nominal rate
  // after a start-up count; a stopped source gives no ticks at all.
  assign fast_ready = fast_osc_on && (fast_cnt == FAST_START);
  assign slow_ready = slow_osc_on && (slow_cnt == SLOW_START);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fast_osc_on <= 1'b0;
      fast_cnt <= '0;
      fast_acc <= '0;
      fast_tick <= 1'b0;
    end else begin
      fast_osc_on <= next_fast_on; // R07
      if (!fast_osc_on) begin
        fast_cnt <= '0;
      end else if (fast_cnt != FAST_START) begin
        fast_cnt <= fast_cnt + 16'h0001;
      end
      if (fast_ready) begin
        {fast_tick, fast_acc} <= {1'b0, fast_acc} +
                                 {1'b0, scpm_pkg::FAST_INC}; // R01
      end else begin
        fast_tick <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slow_osc_on <= 1'b0;
      slow_cnt <= '0;
      slow_acc <= '0;
      slow_tick <= 1'b0;
    end else begin
      slow_osc_on <= next_slow_on;
      if (!slow_osc_on) begin
        slow_cnt <= '0;
      end else if (slow_cnt != SLOW_START) begin
        slow_cnt <= slow_cnt + 16'h0001;
      end
      if (slow_ready) begin
        {slow_tick, slow_acc} <= {1'b0, slow_acc} +
                                 {1'b0, scpm_pkg::SLOW_INC}; // R01
      end else begin
        slow_tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // System clock selection
  // ----------------------------------------------------------------
  assign target_fast = is_fast(fast_clock_select,
                               slow_clock_divider_select);
  assign active_fast = is_fast(active_hl, active_cks);

  always_comb begin
    if (active_hl) begin
      src_tick = fast_tick; // R15
    end else if (active_fast) begin
      src_tick = fast_tick && div_hit(div_cnt, active_cks); // R04 R14
    end else begin
      src_tick = slow_tick; // R14
    end
  end

  // A new setting waits for its source to be ready and for the edge
  // that ends the current period, so no period is ever cut short.
  always_comb begin
    switch_ok = (fast_clock_select != active_hl) ||
                (slow_clock_divider_select != active_cks);
    if (!(target_fast ? fast_ready : slow_ready)) begin
      switch_ok = 1'b0; // R16
    end
    if ((active_fast ? fast_ready : slow_ready) && !src_tick) begin
      switch_ok = 1'b0; // R16
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_hl <= scpm_pkg::HL_RST;
      active_cks <= scpm_pkg::CKS_RST;
      div_cnt <= '0;
    end else begin
      if (switch_ok) begin
        active_hl <= fast_clock_select; // R03
        active_cks <= slow_clock_divider_select;
        div_cnt <= '0;
      end else if (fast_tick) begin
        div_cnt <= div_cnt + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating mode sequencer
  // ----------------------------------------------------------------
  assign run_mode = (mode_state == scpm_pkg::MODE_NORMAL) ||
                    (mode_state == scpm_pkg::MODE_SLOW);
  assign sys_on = run_mode || (mode_state == scpm_pkg::MODE_IDLE1);
  assign sleep_mode = (mode_state == scpm_pkg::MODE_SLEEP0) ||
                      (mode_state == scpm_pkg::MODE_SLEEP1);

  always_comb begin
    next_mode = mode_state;
    unique case (mode_state)
      scpm_pkg::MODE_NORMAL, scpm_pkg::MODE_SLOW: begin
        if (halt_req) begin
          if (!halt_idle_select) begin
            next_mode = wdt_enable ? scpm_pkg::MODE_SLEEP1 // R10
                                   : scpm_pkg::MODE_SLEEP0; // R09
          end else begin
            next_mode = idle_sysclk_keep ? scpm_pkg::MODE_IDLE1 // R13
                                         : scpm_pkg::MODE_IDLE0; // R12
          end
        end else begin
          next_mode = active_fast ? scpm_pkg::MODE_NORMAL // R05
                                  : scpm_pkg::MODE_SLOW; // R06
        end
      end
      scpm_pkg::MODE_IDLE0, scpm_pkg::MODE_IDLE1,
      scpm_pkg::MODE_SLEEP0, scpm_pkg::MODE_SLEEP1: begin
        if (wake_req) begin
          next_mode = active_fast ? scpm_pkg::MODE_NORMAL
                                  : scpm_pkg::MODE_SLOW;
        end
      end
      default: begin
        next_mode = scpm_pkg::MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_state <= scpm_pkg::MODE_NORMAL;
    end else begin
      mode_state <= next_mode; // R08
    end
  end

  // Oscillator run requests. While a switch is pending the old source
  // is kept alive so the hand-over edge can still arrive.
  always_comb begin
    if (run_mode) begin
      next_fast_on = target_fast || active_fast; // R06 R07
    end else begin
      next_fast_on = (mode_state == scpm_pkg::MODE_IDLE1) &&
                     active_fast; // R12 R13
    end
    unique case (mode_state)
      scpm_pkg::MODE_SLEEP0: next_slow_on = 1'b0; // R09
      scpm_pkg::MODE_SLEEP1: next_slow_on = wdt_enable; // R10
      default: next_slow_on = 1'b1; // R05 R12 R13
    endcase
  end

  // ----------------------------------------------------------------
  // Clock enables and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_clock_en <= 1'b0;
      cpu_clock_en <= 1'b0;
      fast_clock_en <= 1'b0;
      sub_clock_en <= 1'b0;
      wdt_clock_en <= 1'b0;
      timebase_clock_en <= 1'b0;
      lvd_active <= 1'b0;
    end else begin
      core_clock_en <= src_tick && sys_on; // R13
      cpu_clock_en <= src_tick && run_mode; // R08
      fast_clock_en <= fast_tick; // R07
      sub_clock_en <= slow_tick;
      wdt_clock_en <= slow_tick && wdt_enable; // R02
      timebase_clock_en <= slow_tick; // R02
      lvd_active <= voltage_detect_enable && !sleep_mode; // R11
    end
  end

endmodule

// ---- testbench/scpm_core_model.sv ----
`timescale 1ns/1ps
module scpm_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Clock enables seen by the core
  input wire logic cpu_clock_en,
  input wire logic core_clock_en,
  input wire logic fast_clock_en,
  // Observations
  output logic [15:0] cpu_ticks,
  output logic [7:0] fast_per_core
);
  // ----------------------------------------------------------------
  // Core activity and divider ratio
  // ----------------------------------------------------------------
  logic [7:0] run;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_ticks <= 16'h0000;
      fast_per_core <= 8'h00;
      run <= 8'h00;
    end else begin
      if (cpu_clock_en) begin
        cpu_ticks <= cpu_ticks + 16'h0001;
      end
      if (core_clock_en) begin
        fast_per_core <= run + 8'(fast_clock_en);
        run <= 8'h00;
      end else begin
        run <= run + 8'(fast_clock_en);
      end
    end
  end
endmodule

// ---- testbench/scpm_ctrl_props.sv ----
`timescale 1ns/1ps
module scpm_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic [scpm_pkg::ADDR_W-1:0] addr,
  input wire logic rd_en,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic [scpm_pkg::DATA_W-1:0] rdata,
  input wire logic core_clock_en,
  input wire logic cpu_clock_en,
  input wire logic sub_clock_en,
  input wire logic wdt_clock_en,
  input wire logic timebase_clock_en,
  input wire logic fast_osc_on,
  input wire logic slow_osc_on,
  input wire logic lvd_active,
  input wire scpm_pkg::scpm_mode_t mode_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Settled-mode tracking
  // ----------------------------------------------------------------
  // Oscillators and enables lag the mode, so only judge a settled mode
  scpm_pkg::scpm_mode_t prev_mode;
  logic [1:0] stay;
  wire steady = (stay == 2'h3) && (mode_state == prev_mode);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_mode <= scpm_pkg::MODE_NORMAL;
      stay <= 2'h0;
    end else begin
      prev_mode <= mode_state;
      if (mode_state != prev_mode) begin
        stay <= 2'h0;
      end else if (stay != 2'h3) begin
        stay <= stay + 2'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  AST_RD_UNMAP: assert property ($past(rd_en) && $past(addr) == 2'h3
    |-> rdata == 8'h00) else $error("unmapped read not zero");
  AST_HALT: assert property (halt_req && |mode_state[1:0]
    |=> |mode_state[5:2]) else $error("halt not taken");
  AST_WAKE: assert property (wake_req && |mode_state[5:2]
    |=> |mode_state[1:0]) else $error("wake not taken");
  AST_CPU_OFF: assert property (steady && |mode_state[5:2]
    |-> !cpu_clock_en) else $error("cpu clock in power save");
  AST_SLEEP0: assert property (steady && mode_state[4]
    |-> !(core_clock_en | sub_clock_en | fast_osc_on | slow_osc_on))
    else $error("clock running in deep sleep");
  AST_SLEEP1: assert property (steady && mode_state[5]
    |-> !core_clock_en && !fast_osc_on) else $error("sleep1 clocks");
  AST_LVD_OFF: assert property (steady && |mode_state[5:4]
    |-> !lvd_active) else $error("detector on in sleep");
  AST_IDLE0: assert property (steady && mode_state[2]
    |-> !core_clock_en && !fast_osc_on && slow_osc_on)
    else $error("idle0 clocks");
  AST_IDLE1: assert property (steady && mode_state[3]
    |-> slow_osc_on && !cpu_clock_en) else $error("idle1 clocks");
  AST_SUB_FEED: assert property (timebase_clock_en == sub_clock_en
    && (!wdt_clock_en || sub_clock_en)) else $error("sub feed wrong");
  AST_CPU_CORE: assert property (cpu_clock_en |-> core_clock_en)
    else $error("cpu tick without system tick");
endmodule
bind scpm_clock_power_ctrl scpm_ctrl_props u_scpm_ctrl_props (
  .clk, .reset, .addr, .rd_en, .halt_req, .wake_req, .rdata,
  .core_clock_en, .cpu_clock_en, .sub_clock_en, .wdt_clock_en,
  .timebase_clock_en, .fast_osc_on, .slow_osc_on, .lvd_active,
  .mode_state
);

// ---- testbench/system_clock_power_mode_ctrl_tb.sv ----
`timescale 1ns/1ps
module system_clock_power_mode_ctrl_tb;
  logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, rd_d = 0;
  logic halt_req = 0, wake_req = 0, wdt_enable = 0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, fpc, e;
  logic core_clock_en, cpu_clock_en, fast_clock_en, sub_clock_en;
  logic fast_osc_on, slow_osc_on, lvd_active;
  logic [15:0] cpu_ticks, t;
  logic [31:0] seed = 32'd53040;
  scpm_pkg::scpm_mode_t mode_state;
  logic [7:0] exp_q[$];
  int fail_count = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // Design and core model
  // ----------------------------------------------------------------
  // Short start-up counts keep the run brief
  scpm_clock_power_ctrl #(.FAST_START_CYC(4), .SLOW_START_CYC(8))
    u_scpm_clock_power_ctrl (.clk, .reset, .addr, .wdata, .wr_en, .rd_en,
    .rdata, .halt_req, .wake_req, .wdt_enable, .core_clock_en,
    .cpu_clock_en, .fast_clock_en, .sub_clock_en, .wdt_clock_en(),
    .timebase_clock_en(), .fast_osc_on, .slow_osc_on, .lvd_active,
    .mode_state);
  scpm_core_model u_scpm_core_model (.clk, .reset, .cpu_clock_en,
    .core_clock_en, .fast_clock_en, .cpu_ticks, .fast_per_core(fpc));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(x);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic pulse(input logic w);
    @(posedge clk);
    halt_req <= !w;
    wake_req <= w;
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  task automatic wait_core(input int n);
    repeat (n) begin
      do @(posedge clk); while (core_clock_en !== 1'b1);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Read monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= rd_en;
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  always @(negedge clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      chk(rdata, e);
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(0, 8'hE2);
    rd(1, 8'h00);
    rd(2, 8'h00);
    wait_core(2);
    repeat (4) begin
      seed = xs(seed);
      wr(1, seed[7:0]);
      wr(2, seed[15:8]);
      wr(3, seed[23:16]);
      rd(1, {seed[7], 7'h00});
      rd(2, {7'h00, seed[8]});
      rd(3, 8'h00);
      chk(lvd_active, seed[8]);
    end
    wr(0, 8'hFF);
    rd(0, 8'hEF);
    for (int c = 2; c < 8; c++) begin
      wr(0, {c[2:0], 5'h00});
      wait_core(4);
      chk(fpc, 8'h01 << (8 - c));
      chk(mode_state, scpm_pkg::MODE_NORMAL);
    end
    wr(0, 8'hE1);
    wait_core(4);
    chk(fpc, 8'h01);
    // Sub clock source; code 000 must keep it
    wr(0, 8'h20);
    wait_core(2);
    wr(0, 8'h00);
    wait_core(1);
    chk(mode_state, scpm_pkg::MODE_SLOW);
    chk(fast_osc_on, 1'b0);
    wr(0, 8'hE1);
    wait_core(3);
    chk(mode_state, scpm_pkg::MODE_NORMAL);
    chk(fast_osc_on, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(0, {6'h38, i[1], 1'b1});
      wr(1, {i[0], 7'h00});
      wr(2, 8'h01);
      wdt_enable <= i[0];
      pulse(1'b0);
      // Let the last tick launched before the halt reach the count
      repeat (2) @(posedge clk);
      t = cpu_ticks;
      repeat (18) @(posedge clk);
      chk(mode_state, 6'h01 << (i[1] ? 2 + i[0] : 4 + i[0]));
      chk(cpu_ticks - t, 8'h00);
      chk(lvd_active, i[1]);
      chk(slow_osc_on, i != 0);
      chk(fast_osc_on, i == 3);
      pulse(1'b1);
      wait_core(2);
      chk(mode_state, scpm_pkg::MODE_NORMAL);
    end
    pulse(1'b1);
    repeat (3) @(posedge clk);
    chk(mode_state, scpm_pkg::MODE_NORMAL);
    complete_run();
  end
endmodule
